// ===== lsw_defines.svh
// constants for the lap stopwatch block: tick periods, widths, unit codes
// assumes a 200 MHz system clock
`ifndef LSW_DEFINES_SVH
`define LSW_DEFINES_SVH

`define LSW_CLK_PERIOD_NS   5
`define LSW_TICK_MS         10
`define LSW_TICK_CYCLES     ((`LSW_TICK_MS * 1000000) / `LSW_CLK_PERIOD_NS)
`define LSW_TIME_W          16
`define LSW_DIV_W           32
`define LSW_HSEC_PER_SEC    100
`define LSW_HSEC_PER_MIN    6000
`define LSW_HSEC_PER_HOUR   360000
`define LSW_UNIT_HOURS      2'h0
`define LSW_UNIT_MINUTES    2'h1
`define LSW_UNIT_SECONDS    2'h2
`define LSW_UNIT_HSEC       2'h3

`endif

// ===== lsw_pkg.sv
// types shared by the lap stopwatch block
// assumes lsw_defines.svh is on the include path
`default_nettype none
`include "lsw_defines.svh"

package lsw_pkg;
    typedef logic [1:0] lsw_unit_type;
    typedef logic [`LSW_TIME_W-1:0] lsw_time_type;
    // the three control inputs that other program blocks drive
    typedef struct packed {
        logic enable;
        logic lap;
        logic clear;
    } lsw_ctrl_type;
    typedef enum logic [1:0] {LSW_IDLE, LSW_RUN, LSW_HOLD} lsw_state_type;
endpackage

`default_nettype wire

// ===== lsw_tick_gen.sv
// hundredth-second tick and unit prescaler for the lap stopwatch
// assumes clk_sys at 200 MHz; TICK_CYCLES may be shortened in simulation
`timescale 1ns/100ps
`default_nettype none
`include "lsw_defines.svh"

module lsw_tick_gen
    import lsw_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `LSW_TICK_CYCLES
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    input  wire logic         restart,
    input  wire logic         running,
    input  wire lsw_unit_type unitSel,
    output logic              unitTick
);
    logic [`LSW_DIV_W-1:0] cycleCount;
    logic [`LSW_DIV_W-1:0] hsecCount;
    logic [`LSW_DIV_W-1:0] hsecLimit;
    wire                   hsecTick;
    wire                   hsecWrap;

    // restart aligns the prescalers so a fresh run starts from a full unit
    assign hsecTick = running && (cycleCount == TICK_CYCLES[`LSW_DIV_W-1:0] - 32'h1);
    assign hsecWrap = hsecTick && (hsecCount == hsecLimit - 32'h1);
    assign unitTick = hsecWrap;

    // hundredths per unit of the chosen time base
    always_comb begin
        case (unitSel)
            `LSW_UNIT_HOURS:   hsecLimit = `LSW_HSEC_PER_HOUR;
            `LSW_UNIT_MINUTES: hsecLimit = `LSW_HSEC_PER_MIN;
            `LSW_UNIT_SECONDS: hsecLimit = `LSW_HSEC_PER_SEC;
            default:           hsecLimit = 32'h1;    // RULE_10
        endcase
    end

    // prescalers freeze while stopped; the restart on each enable rise clears them, so no partial unit outlasts a pause
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cycleCount <= '0;
            hsecCount  <= '0;
        end else if (restart) begin
            cycleCount <= '0;
            hsecCount  <= '0;
        end else if (running) begin
            cycleCount <= hsecTick ? '0 : cycleCount + 32'h1;
            if (hsecTick) begin
                hsecCount <= hsecWrap ? '0 : hsecCount + 32'h1;
            end
        end
    end
endmodule

`default_nettype wire

// ===== lsw_stopwatch.sv
// lap stopwatch: elapsed time with lap capture on a 16-bit result
// assumes synchronous control inputs from other program blocks
//
// Functional notes
// [RULE_01] enable rising clears elapsed time and result, then counting starts
// [RULE_02] enable falling freezes the elapsed time at its present value
// [RULE_03] lap rising captures elapsed time as lap time and shows it
// [RULE_04] enable and lap high: counting continues, result shows lap time
// [RULE_05] lap falling returns the result to the running elapsed time
// [RULE_06] enable high, lap low: result follows running elapsed time
// [RULE_07] enable low, lap high: result shows the stored lap time
// [RULE_08] both low: result shows last elapsed value before stopping
// [RULE_09] reset input clears both elapsed time and lap time
// [RULE_10] time base hours, minutes, seconds or hundredths; finest is 10 ms
// [RULE_11] reset input overrides enable and lap every tick it is high
`timescale 1ns/100ps
`default_nettype none
`include "lsw_defines.svh"

module lsw_stopwatch
    import lsw_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `LSW_TICK_CYCLES
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    input  wire lsw_ctrl_type ctrl,
    input  wire lsw_unit_type unitSel,
    output lsw_time_type      timeResultOutput,
    output logic              counting
);
    lsw_ctrl_type  ctrlLast;
    lsw_time_type  elapsed;
    lsw_time_type  lapTime;
    lsw_state_type state;
    lsw_state_type next_state;
    lsw_time_type  next_result;
    wire           enRise;
    wire           enFall;
    wire           lapRise;
    wire           unitTick;
    wire           showLap;

    // edge detection against the previous program tick
    assign enRise  = ctrl.enable && !ctrlLast.enable;
    assign enFall  = !ctrl.enable && ctrlLast.enable;
    assign lapRise = ctrl.lap && !ctrlLast.lap;
    assign showLap = ctrl.lap;                        // RULE_07

    lsw_tick_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .restart  (ctrl.clear || enRise),
        .running  (state == LSW_RUN),
        .unitSel  (unitSel),
        .unitTick (unitTick)
    );

    // run state follows enable edges; clear drops back to idle
    always_comb begin
        next_state = state;
        case (state)
            LSW_IDLE: if (enRise) next_state = LSW_RUN;      // RULE_01
            LSW_RUN:  if (enFall) next_state = LSW_HOLD;     // RULE_02
            LSW_HOLD: if (enRise) next_state = LSW_RUN;
            default:  next_state = LSW_IDLE;
        endcase
        if (ctrl.clear) begin
            next_state = LSW_IDLE;                           // RULE_11
        end
    end

    // result selection: lap held while lap is high, else elapsed
    always_comb begin
        if (ctrl.clear || enRise) begin
            next_result = '0;                                // RULE_01
        end else if (lapRise) begin
            next_result = elapsed;                           // RULE_03
        end else if (showLap) begin
            next_result = lapTime;                           // RULE_04
        end else begin
            next_result = elapsed;                           // RULE_05 RULE_06 RULE_08
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrlLast <= '0;
            state    <= LSW_IDLE;
        end else begin
            ctrlLast <= ctrl;
            state    <= next_state;
        end
    end

    // elapsed counter wraps at full scale; a long run in hundredths overflows
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            elapsed <= '0;
        end else if (ctrl.clear) begin
            elapsed <= '0;                                   // RULE_09 RULE_11
        end else if (enRise) begin
            elapsed <= '0;                                   // RULE_01
        end else if (state == LSW_RUN && unitTick) begin
            elapsed <= elapsed + 16'h1;                      // RULE_10
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lapTime <= '0;
        end else if (ctrl.clear) begin
            lapTime <= '0;                                   // RULE_09
        end else if (lapRise) begin
            lapTime <= elapsed;                              // RULE_03
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            timeResultOutput <= '0;
            counting         <= 1'b0;
        end else begin
            timeResultOutput <= next_result;
            counting         <= (next_state == LSW_RUN);
        end
    end

    // checks
    sequence enableEdgeUp;
        !ctrl.clear && ctrl.enable && !ctrlLast.enable;
    endsequence

    property startClears;
        @(posedge clk_sys) disable iff (!rst_b)
        enableEdgeUp |=> (elapsed == '0) && (timeResultOutput == '0) && counting;
    endproperty
    start_clears_a: assert property (startClears) // RULE_01
        else $error("enable rise did not clear and start");

    freeze_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_02
        (state == LSW_HOLD && !ctrl.clear && !enRise) |=> $stable(elapsed))
        else $error("elapsed moved while stopped");

    lap_capture_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_03
        (lapRise && !ctrl.clear && !enRise) |=> (lapTime == $past(elapsed))
            && (timeResultOutput == $past(elapsed)))
        else $error("lap capture wrong");

    lap_shown_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_04
        (ctrl.lap && ctrlLast.lap && !ctrl.clear && !enRise) |=> timeResultOutput == $past(lapTime))
        else $error("lap time not shown");

    run_shown_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_06
        (!ctrl.lap && !ctrl.clear && !enRise) |=> timeResultOutput == $past(elapsed))
        else $error("elapsed time not shown");

    clear_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_11
        ctrl.clear |=> (elapsed == '0) && (lapTime == '0) && !counting)
        else $error("clear did not zero both times");

    count_step_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_10
        (elapsed != $past(elapsed) && $past(!ctrl.clear && !enRise))
            |-> elapsed == $past(elapsed) + 16'h1)
        else $error("elapsed step not one unit");

    hold_last_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_08
        (state == LSW_HOLD && !ctrl.lap && !ctrl.enable && !ctrl.clear) [*2]
            |-> timeResultOutput == elapsed)
        else $error("stopped output not last elapsed");
endmodule

`default_nettype wire

// ===== lsw_ctrl_model.sv
// partner model: the program blocks that drive the stopwatch controls
// assumes bench requests; they reach the design only at falling edges
`timescale 1ns/100ps
`default_nettype none

module lsw_ctrl_model
    import lsw_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire lsw_ctrl_type ctrlReq,
    input  wire lsw_unit_type unitReq,
    output lsw_ctrl_type      ctrl,
    output lsw_unit_type      unitSel
);
    // idle controls from time zero, so reset never sees unknowns
    initial begin
        ctrl = '0;
        unitSel = 2'h3;
    end
    // launch on the falling edge so the design samples settled levels
    always @(negedge clk_sys) begin
        ctrl <= ctrlReq;
        unitSel <= unitReq;
    end
endmodule

`default_nettype wire

// ===== tb_lap_stopwatch.sv
// self-checking bench for the lap stopwatch
// assumes lsw_pkg compiled first; tick shortened to 4 cycles
`timescale 1ns/100ps
`default_nettype none

module tb_lap_stopwatch;
    import lsw_pkg::*;
    typedef struct {lsw_unit_type u; int n; int lo; int hi;} lsw_row_type;
    logic         clk_sys = 1'b0;
    logic         rst_b   = 1'b0;
    lsw_ctrl_type ctrlReq = '0;
    lsw_unit_type unitReq = 2'h3;
    lsw_ctrl_type ctrl;
    lsw_unit_type unitSel;
    lsw_time_type res;
    lsw_time_type lapVal;
    logic         counting;
    int           n_fail  = 0;
    int           checked = 0;
    int           cycles  = 0;
    // unit, run cycles, allowed count range (tick is 4 cycles)
    lsw_row_type  rows[4] = '{'{2'h3, 400, 99, 101}, '{2'h2, 4000, 9, 11},
                              '{2'h1, 4000, 0, 0}, '{2'h0, 4000, 0, 0}};

    lsw_ctrl_model ctrl_u (.clk_sys(clk_sys), .ctrlReq(ctrlReq), .unitReq(unitReq),
                           .ctrl(ctrl), .unitSel(unitSel));
    lsw_stopwatch #(.TICK_CYCLES(4)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .ctrl(ctrl),
        .unitSel(unitSel), .timeResultOutput(res), .counting(counting));

    always #2.5 clk_sys = ~clk_sys;

    // hang guard: whole run needs about 13000 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // two edges: the first samples the request and registers the answer, the second is slack
    task automatic setc(input logic e, input logic l, input logic c);
        ctrlReq = '{enable: e, lap: l, clear: c};
        cyc(2);
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checked %0d failed %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        cyc(5);
        check("reset result", {16'h0, res}, 32'h0);
        @(negedge clk_sys) rst_b = 1'b1;
        // one edge clear of the release, so no request races the model's negedge
        cyc(1);
        // each time base: restart, run, freeze, compare the frozen count
        foreach (rows[i]) begin
            unitReq = rows[i].u;
            setc(1'b0, 1'b0, 1'b1);
            setc(1'b1, 1'b0, 1'b0);
            cyc(rows[i].n);
            setc(1'b0, 1'b0, 1'b0);
            check("rate", {31'h0, (res >= rows[i].lo && res <= rows[i].hi)}, 32'h1);
        end
        // the rate rows leave the hours base selected; go back to hundredths
        unitReq = 2'h3;
        setc(1'b1, 1'b0, 1'b0);
        check("start", {15'h0, counting, res}, 32'h10000);
        cyc(80);
        check("running", {31'h0, (res >= 19 && res <= 21)}, 32'h1);
        setc(1'b1, 1'b1, 1'b0);
        lapVal = res;
        check("lap taken", {31'h0, (lapVal >= 19 && lapVal <= 21)}, 32'h1);
        cyc(40);
        check("lap shown", {15'h0, counting, res}, {16'h1, lapVal});
        setc(1'b1, 1'b0, 1'b0);
        check("lap off", {31'h0, (res > lapVal + 8)}, 32'h1);
        // second lap while running, then stop with lap still high so the
        // stored lap time and the frozen elapsed time differ
        setc(1'b1, 1'b1, 1'b0);
        lapVal = res;
        cyc(20);
        setc(1'b0, 1'b1, 1'b0);
        check("lap stopped", {15'h0, counting, res}, {16'h0, lapVal});
        setc(1'b0, 1'b0, 1'b0);
        check("held", {31'h0, (res > lapVal && res <= lapVal + 7)}, 32'h1);
        lapVal = res;
        cyc(40);
        check("frozen", {15'h0, counting, res}, {16'h0, lapVal});
        setc(1'b1, 1'b0, 1'b0);
        check("restart", {16'h0, res}, 32'h0);
        cyc(40);
        setc(1'b1, 1'b1, 1'b1);
        cyc(40);
        check("clear wins", {15'h0, counting, res}, 32'h0);
        setc(1'b0, 1'b1, 1'b0);
        check("lap cleared", {16'h0, res}, 32'h0);
        setc(1'b1, 1'b0, 1'b0);
        cyc(40);
        @(negedge clk_sys) rst_b = 1'b0;
        #1;
        check("async reset", {15'h0, counting, res}, 32'h0);
        stop_test();
    end
endmodule

`default_nettype wire
